// ==== logic/srr_regs.svh ====
`ifndef SRR_REGS_SVH
`define SRR_REGS_SVH

// register select codes on the command port
`define SRR_SEL_OP_EVENT   3'h0
`define SRR_SEL_OP_LIVE    3'h1
`define SRR_SEL_OP_ENABLE  3'h2
`define SRR_SEL_OP_FALL    3'h3
`define SRR_SEL_OP_RISE    3'h4
`define SRR_SEL_QS_EVENT   3'h5
`define SRR_SEL_QS_LIVE    3'h6
`define SRR_SEL_QS_ENABLE  3'h7

// operation group field positions
`define SRR_POWER_UP_BIT   7
`define SRR_CMD_ERR_BIT    5
`define SRR_EXE_ERR_BIT    4
`define SRR_DEV_ERR_BIT    3
`define SRR_QRY_ERR_BIT    2
`define SRR_OP_USED_MASK   16'h00bc

// status byte summary positions
`define SRR_SB_OP_BIT      7
`define SRR_SB_QS_BIT      3

// reset values
`define SRR_OP_EVENT_RST   16'h0080
`define SRR_OP_ENABLE_RST  16'h0000
`define SRR_OP_RISE_RST    16'h00bc
`define SRR_OP_FALL_RST    16'h0000
`define SRR_QS_ENABLE_RST  16'h0000

`endif

// ==== logic/srr_pkg.sv ====
package srr_pkg;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [2:0]  sel;
        logic [15:0] data;
    } srr_cmd_t;

    typedef struct packed {
        logic valid;
        logic [15:0] data;
    } srr_rsp_t;

    typedef struct packed {
        logic cmdErr;
        logic exeErr;
        logic devErr;
        logic qryErr;
    } srr_err_t;

    typedef struct packed {
        logic        powerUp;
        logic [15:0] opPrev;
        logic [15:0] opEvent;
        logic [15:0] opEnable;
        logic [15:0] opRise;
        logic [15:0] opFall;
        logic [15:0] qsPrev;
        logic [15:0] qsEvent;
        logic [15:0] qsEnable;
        srr_rsp_t    rsp;
        logic [7:0]  statusByte;
    } srr_state_t;

endpackage

// ==== logic/srr_status.sv ====
`timescale 1ns/1ps
`include "srr_regs.svh"

// Overview of operation
// - power-up flag at bit 7 set after reset, held until read
// - command, execution, device, query errors sit at bits 5, 4, 3, 2
// - operation live state follows present conditions, only the power-up bit 7 held
// - operation events latch each edge enabled in the rise or fall mask, read clears them
// - writing operation enable stores a per-bit mask over events
// - status byte bit 7 is OR of enabled operation events
// - reading operation enable returns the mask unchanged
// - operation group has a writable falling edge enable
// - operation group has a writable rising edge enable
// - questionable events: 16-bit latch since last read, read clears
// - questionable live state: 16 bits, unlatched
// - writing questionable enable stores the summary mask
// - status byte bit 3 is OR of enabled questionable events
// - reading questionable enable returns the stored 16-bit mask
// - one means active or enabled, zero inactive or disabled
module srr_status (
    input  wire logic             clk_sys,
    input  wire logic             arst_n,
    input  wire srr_pkg::srr_cmd_t cmd,
    input  wire srr_pkg::srr_err_t errLive,
    input  wire logic [15:0]      qsLive,
    output srr_pkg::srr_rsp_t     rsp,
    output logic [7:0]            statusByte
);

    srr_pkg::srr_state_t s;
    srr_pkg::srr_state_t next_s;

    logic [15:0] opLive;
    logic [15:0] opSet;
    logic [15:0] qsSet;
    logic        isRead;
    logic        isWrite;
    logic        rdOpEvent;
    logic        rdOpLive;
    logic        rdQsEvent;
    logic [15:0] rdData;

    assign isRead    = cmd.valid && !cmd.write;
    assign isWrite   = cmd.valid && cmd.write;
    assign rdOpEvent = isRead && (cmd.sel == `SRR_SEL_OP_EVENT);
    assign rdOpLive  = isRead && (cmd.sel == `SRR_SEL_OP_LIVE);
    assign rdQsEvent = isRead && (cmd.sel == `SRR_SEL_QS_EVENT);

    // live operation state, unused bits tied low
    always_comb begin
        opLive = 16'h0000;
        opLive[`SRR_POWER_UP_BIT] = s.powerUp;
        opLive[`SRR_CMD_ERR_BIT]  = errLive.cmdErr;
        opLive[`SRR_EXE_ERR_BIT]  = errLive.exeErr;
        opLive[`SRR_DEV_ERR_BIT]  = errLive.devErr;
        opLive[`SRR_QRY_ERR_BIT]  = errLive.qryErr;
    end

    // edge detection against last cycle's live state
    assign opSet = ((opLive & ~s.opPrev & s.opRise)
                 | (~opLive & s.opPrev & s.opFall))
                 & `SRR_OP_USED_MASK;
    // questionable group has no edge selects: latch on rise
    assign qsSet = qsLive & ~s.qsPrev;

    always_comb begin
        rdData = 16'h0000;
        case (cmd.sel)
            `SRR_SEL_OP_EVENT:  rdData = s.opEvent;
            `SRR_SEL_OP_LIVE:   rdData = opLive;
            `SRR_SEL_OP_ENABLE: rdData = s.opEnable;
            `SRR_SEL_QS_EVENT:  rdData = s.qsEvent;
            `SRR_SEL_QS_LIVE:   rdData = qsLive;
            `SRR_SEL_QS_ENABLE: rdData = s.qsEnable;
            default:            rdData = 16'h0000;
        endcase
    end

    always_comb begin
        next_s = s;
        next_s.opPrev = opLive;
        next_s.qsPrev = qsLive;
        // power-up flag drops once its bit has been read
        if (rdOpEvent || rdOpLive) begin
            next_s.powerUp = 1'b0;
        end
        // set wins over the read-clear
        next_s.opEvent = ((rdOpEvent ? 16'h0000 : s.opEvent) | opSet)
                       & `SRR_OP_USED_MASK;
        next_s.qsEvent = (rdQsEvent ? 16'h0000 : s.qsEvent)
                       | qsSet;
        if (isWrite) begin
            case (cmd.sel)
                `SRR_SEL_OP_ENABLE: begin
                    next_s.opEnable = cmd.data & `SRR_OP_USED_MASK;
                end
                `SRR_SEL_OP_FALL: begin
                    next_s.opFall = cmd.data & `SRR_OP_USED_MASK;
                end
                `SRR_SEL_OP_RISE: begin
                    next_s.opRise = cmd.data & `SRR_OP_USED_MASK;
                end
                `SRR_SEL_QS_ENABLE: begin
                    next_s.qsEnable = cmd.data;
                end
                default: begin
                    next_s.opEnable = s.opEnable;
                end
            endcase
        end
        next_s.rsp.valid = isRead;
        next_s.rsp.data  = isRead ? rdData : 16'h0000;
        // summaries follow the values registered this same edge
        next_s.statusByte = 8'h00;
        next_s.statusByte[`SRR_SB_OP_BIT] =
            |(next_s.opEvent & next_s.opEnable);
        next_s.statusByte[`SRR_SB_QS_BIT] =
            |(next_s.qsEvent & next_s.qsEnable);
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s.powerUp    <= 1'b1;
            s.opPrev     <= 16'h0000;
            s.opEvent    <= `SRR_OP_EVENT_RST;
            s.opEnable   <= `SRR_OP_ENABLE_RST;
            s.opRise     <= `SRR_OP_RISE_RST;
            s.opFall     <= `SRR_OP_FALL_RST;
            s.qsPrev     <= 16'h0000;
            s.qsEvent    <= 16'h0000;
            s.qsEnable   <= `SRR_QS_ENABLE_RST;
            s.rsp        <= '0;
            s.statusByte <= 8'h00;
        end else begin
            s <= next_s;
        end
    end

    assign rsp        = s.rsp;
    assign statusByte = s.statusByte;

    // checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    logic rdOpEnable;
    logic rdQsEnable;
    logic wrOpEnable;
    logic wrQsEnable;
    logic wrOpFall;
    logic wrOpRise;
    logic opRead;
    logic [15:0] opRiseHit;
    logic [15:0] opFallHit;
    logic [15:0] qsRiseHit;

    assign rdOpEnable = isRead && (cmd.sel == `SRR_SEL_OP_ENABLE);
    assign rdQsEnable = isRead && (cmd.sel == `SRR_SEL_QS_ENABLE);
    assign wrOpEnable = isWrite && (cmd.sel == `SRR_SEL_OP_ENABLE);
    assign wrQsEnable = isWrite && (cmd.sel == `SRR_SEL_QS_ENABLE);
    assign wrOpFall   = isWrite && (cmd.sel == `SRR_SEL_OP_FALL);
    assign wrOpRise   = isWrite && (cmd.sel == `SRR_SEL_OP_RISE);
    assign opRead     = rdOpEvent || rdOpLive || rdOpEnable;
    assign opRiseHit  = opLive & ~s.opPrev & s.opRise;
    assign opFallHit  = ~opLive & s.opPrev & s.opFall;
    assign qsRiseHit  = qsLive & ~s.qsPrev;

    chk_power_up_hold: assert property (
        $fell(s.powerUp) |-> $past(rdOpEvent) || $past(rdOpLive))
        else $error("power-up flag dropped without a read");

    chk_power_up_seen: assert property (
        rdOpLive && s.powerUp |=> rsp.valid && rsp.data[7])
        else $error("power-up flag not shown on live read");

    chk_error_map: assert property (
        rdOpLive |=> rsp.data[5:2] == $past(errLive))
        else $error("error flags at wrong bit positions");

    chk_live_follow: assert property (
        rdOpLive |=> rsp.data == $past(opLive))
        else $error("operation live read not current");

    chk_op_event_clear: assert property (
        rdOpEvent |=> rsp.data == $past(s.opEvent)
            && s.opEvent == $past(opSet))
        else $error("operation event read did not clear");

    chk_op_event_hold: assert property (
        !rdOpEvent ##1 1'b1 |-> (s.opEvent & $past(s.opEvent))
            == $past(s.opEvent))
        else $error("operation event lost without a read");

    chk_op_enable_store: assert property (
        wrOpEnable |=> s.opEnable == ($past(cmd.data)
            & `SRR_OP_USED_MASK))
        else $error("operation enable not stored");

    chk_op_summary: assert property (
        statusByte[7] == |(s.opEvent & s.opEnable))
        else $error("operation summary bit wrong");

    chk_op_enable_read: assert property (
        rdOpEnable && !isWrite |=> rsp.data == $past(s.opEnable)
            && $stable(s.opEnable))
        else $error("operation enable read wrong or altered");

    chk_fall_store: assert property (
        wrOpFall |=> s.opFall == ($past(cmd.data) & `SRR_OP_USED_MASK))
        else $error("falling edge enable not stored");

    chk_rise_store: assert property (
        wrOpRise |=> s.opRise == ($past(cmd.data) & `SRR_OP_USED_MASK))
        else $error("rising edge enable not stored");

    chk_qs_event_clear: assert property (
        rdQsEvent |=> rsp.data == $past(s.qsEvent)
            && s.qsEvent == $past(qsSet))
        else $error("questionable event read did not clear");

    chk_qs_live_follow: assert property (
        isRead && cmd.sel == `SRR_SEL_QS_LIVE |=> rsp.data == $past(qsLive))
        else $error("questionable live read not current");

    chk_qs_enable_store: assert property (
        wrQsEnable |=> s.qsEnable == $past(cmd.data))
        else $error("questionable enable not stored");

    chk_qs_summary: assert property (
        statusByte[3] == |(s.qsEvent & s.qsEnable))
        else $error("questionable summary bit wrong");

    chk_qs_enable_read: assert property (
        rdQsEnable |=> rsp.data == $past(s.qsEnable))
        else $error("questionable enable read wrong");

    chk_byte_polarity: assert property (
        (statusByte & 8'h77) == 8'h00)
        else $error("status byte bit set outside summaries");

    chk_rise_latch: assert property (
        (opLive[4] && !s.opPrev[4] && s.opRise[4]) |=> s.opEvent[4])
        else $error("rising edge did not latch event");

    chk_fall_latch: assert property (
        (!opLive[2] && s.opPrev[2] && s.opFall[2]) |=> s.opEvent[2])
        else $error("falling edge did not latch event");

    chk_unused_zero: assert property (
        opRead |=> (rsp.data & ~`SRR_OP_USED_MASK) == 16'h0000)
        else $error("unused operation bit read nonzero");

    chk_power_up_stay: assert property (
        !s.powerUp |=> !s.powerUp)
        else $error("power-up flag came back without a reset");

    chk_power_up_bit: assert property (
        rdOpLive |=> rsp.data[`SRR_POWER_UP_BIT] == $past(s.powerUp))
        else $error("power-up flag not at its bit on live read");

    chk_op_event_unused: assert property (
        (s.opEvent & ~`SRR_OP_USED_MASK) == 16'h0000)
        else $error("unused operation event bit set");

    chk_op_enable_unused: assert property (
        (s.opEnable & ~`SRR_OP_USED_MASK) == 16'h0000)
        else $error("unused operation enable bit set");

    chk_op_enable_hold: assert property (
        !wrOpEnable |=> $stable(s.opEnable))
        else $error("operation enable changed without a write");

    chk_qs_enable_hold: assert property (
        !wrQsEnable |=> $stable(s.qsEnable))
        else $error("questionable enable changed without a write");

    chk_qs_event_hold: assert property (
        !rdQsEvent |=> (s.qsEvent & $past(s.qsEvent))
            == $past(s.qsEvent))
        else $error("questionable event lost without a read");

    chk_qs_rise_latch: assert property (
        qsRiseHit != 16'h0000 |=> (s.qsEvent & $past(qsRiseHit))
            == $past(qsRiseHit))
        else $error("questionable rise not latched");

    chk_qs_no_stray: assert property (
        (s.qsEvent & ~$past(s.qsEvent) & ~$past(qsRiseHit))
            == 16'h0000)
        else $error("questionable event set without a rise");

    chk_rise_any: assert property (
        opRiseHit != 16'h0000 |=> (s.opEvent & $past(opRiseHit))
            == $past(opRiseHit))
        else $error("enabled rising edge not latched");

    chk_fall_any: assert property (
        opFallHit != 16'h0000 |=> (s.opEvent & $past(opFallHit))
            == $past(opFallHit))
        else $error("enabled falling edge not latched");

    chk_no_stray_event: assert property (
        (s.opEvent & ~$past(s.opEvent) & ~$past(opRiseHit)
            & ~$past(opFallHit)) == 16'h0000)
        else $error("operation event set without an enabled edge");

    chk_rsp_idle: assert property (
        !isRead |=> !rsp.valid && rsp.data == 16'h0000)
        else $error("answer shown without a read");

    chk_rsp_answer: assert property (
        isRead |=> rsp.valid)
        else $error("read got no answer");

    chk_wo_read_zero: assert property (
        isRead && (cmd.sel == `SRR_SEL_OP_FALL
            || cmd.sel == `SRR_SEL_OP_RISE) |=> rsp.data == 16'h0000)
        else $error("write-only register read nonzero");

    chk_op_summary_clear: assert property (
        rdOpEvent && opSet == 16'h0000 |=> !statusByte[`SRR_SB_OP_BIT])
        else $error("operation summary stayed after read clear");

    chk_qs_summary_clear: assert property (
        rdQsEvent && qsRiseHit == 16'h0000 |=> !statusByte[`SRR_SB_QS_BIT])
        else $error("questionable summary stayed after read clear");

    chk_op_no_mask: assert property (
        s.opEnable == 16'h0000 |-> !statusByte[`SRR_SB_OP_BIT])
        else $error("operation summary set with empty mask");

    chk_qs_no_mask: assert property (
        s.qsEnable == 16'h0000 |-> !statusByte[`SRR_SB_QS_BIT])
        else $error("questionable summary set with empty mask");

    cov_op_summary: cover property (
        wrOpEnable ##[1:20] $rose(statusByte[7]));
    cov_qs_summary: cover property (
        $rose(statusByte[3]) ##[1:20] rdQsEvent);
    cov_set_on_clear: cover property (
        rdOpEvent && (opSet != 16'h0000));
    cov_power_up_read: cover property (
        $fell(s.powerUp));
    cov_fall_edge: cover property (
        wrOpFall ##[1:40] (opFallHit != 16'h0000));

endmodule // srr_status

// ==== test/srr_ctrl_model.sv ====
`timescale 1ns/1ps
module srr_ctrl_model (
    input  wire logic              clk_sys,
    output srr_pkg::srr_cmd_t      cmd,
    input  wire srr_pkg::srr_rsp_t rsp
);
    initial cmd = '0;

    // released data lines show the inverse of the last word
    task automatic wr(input logic [2:0] sel, input logic [15:0] d);
        @(negedge clk_sys);
        cmd = '{valid: 1'b1, write: 1'b1, sel: sel, data: d};
        @(negedge clk_sys);
        cmd.valid = 1'b0;
        cmd.data  = ~d;
    endtask

    task automatic rd(input logic [2:0] sel, output logic [15:0] d,
                      output logic ok);
        int i;
        ok = 1'b0;
        d  = '0;
        @(negedge clk_sys);
        cmd.valid = 1'b1;
        cmd.write = 1'b0;
        cmd.sel   = sel;
        @(negedge clk_sys);
        cmd.valid = 1'b0;
        for (i = 0; i < 4 && !ok; i++) begin
            if (rsp.valid === 1'b1) begin
                ok = 1'b1;
                d  = rsp.data;
            end else begin
                @(negedge clk_sys);
            end
        end
    endtask
endmodule // srr_ctrl_model

// ==== test/srr_status_tb.sv ====
`timescale 1ns/1ps
`include "srr_regs.svh"
module srr_status_tb;
    logic              clk_sys    = 1'b0;
    logic              arst_n     = 1'b0;
    srr_pkg::srr_cmd_t cmd;
    srr_pkg::srr_rsp_t rsp;
    srr_pkg::srr_err_t errLive    = '0;
    logic [15:0]       qsLive     = '0;
    logic [7:0]        statusByte;
    int                badCount   = 0;
    int                nChecks    = 0;
    int                k;

    always #2.5 clk_sys = ~clk_sys;

    srr_status u_srr_status (
        .clk_sys    (clk_sys),
        .arst_n     (arst_n),
        .cmd        (cmd),
        .errLive    (errLive),
        .qsLive     (qsLive),
        .rsp        (rsp),
        .statusByte (statusByte)
    );

    srr_ctrl_model u_srr_ctrl_model (
        .clk_sys (clk_sys),
        .cmd     (cmd),
        .rsp     (rsp)
    );

    task automatic wrapUp;
        $display("checks %0d mismatches %0d", nChecks, badCount);
        if (badCount == 0 && nChecks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chkVal(string n, logic [15:0] e, logic [15:0] g);
        nChecks++;
        if (g !== e) begin
            badCount++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chkSb(logic [7:0] e);
        nChecks++;
        if (statusByte !== e) begin
            badCount++;
            $display("ERROR statusByte expected %h seen %h", e, statusByte);
        end
    endtask

    task automatic rdChk(logic [2:0] s, logic [15:0] e, string n);
        logic [15:0] d;
        logic        ok;
        u_srr_ctrl_model.rd(s, d, ok);
        if (!ok) begin
            badCount++;
            $display("ERROR %s expected answer seen none", n);
            wrapUp();
        end else begin
            chkVal(n, e, d);
        end
    endtask

    task automatic wr(logic [2:0] s, logic [15:0] d);
        u_srr_ctrl_model.wr(s, d);
    endtask

    task automatic idle(int n);
        repeat (n) @(negedge clk_sys);
    endtask

    initial begin
        idle(16);
        arst_n = 1'b1;
        chkSb(8'h00);
        rdChk(`SRR_SEL_OP_ENABLE, 16'h0000, "opEnable");
        rdChk(`SRR_SEL_OP_LIVE, 16'h0080, "opLive");
        rdChk(`SRR_SEL_OP_EVENT, 16'h0080, "opEvent");
        rdChk(`SRR_SEL_OP_LIVE, 16'h0000, "opLive");
        rdChk(`SRR_SEL_OP_EVENT, 16'h0000, "opEvent");
        wr(`SRR_SEL_OP_ENABLE, 16'hffff);
        rdChk(`SRR_SEL_OP_ENABLE, 16'h00bc, "opEnable");
        chkSb(8'h00);
        for (k = 0; k < 4; k++) begin
            errLive = srr_pkg::srr_err_t'(4'h8 >> k);
            idle(2);
            chkSb(8'h80);
            rdChk(`SRR_SEL_OP_LIVE, 16'h0020 >> k, "opLive");
            rdChk(`SRR_SEL_OP_EVENT, 16'h0020 >> k, "opEvent");
            errLive = '0;
            idle(2);
            rdChk(`SRR_SEL_OP_EVENT, 16'h0000, "opEvent");
            chkSb(8'h00);
        end
        // only the falling edge of the query error is armed
        wr(`SRR_SEL_OP_FALL, 16'h0004);
        wr(`SRR_SEL_OP_RISE, 16'h0000);
        rdChk(`SRR_SEL_OP_FALL, 16'h0000, "opFall");
        errLive = 4'h1;
        idle(2);
        rdChk(`SRR_SEL_OP_EVENT, 16'h0000, "opEvent");
        errLive = '0;
        idle(2);
        rdChk(`SRR_SEL_OP_EVENT, 16'h0004, "opEvent");
        wr(`SRR_SEL_QS_ENABLE, 16'h8001);
        rdChk(`SRR_SEL_QS_ENABLE, 16'h8001, "qsEnable");
        qsLive = 16'h0100;
        idle(2);
        chkSb(8'h00);
        rdChk(`SRR_SEL_QS_LIVE, 16'h0100, "qsLive");
        rdChk(`SRR_SEL_QS_EVENT, 16'h0100, "qsEvent");
        rdChk(`SRR_SEL_QS_EVENT, 16'h0000, "qsEvent");
        qsLive = 16'h8100;
        idle(2);
        chkSb(8'h08);
        wr(`SRR_SEL_QS_EVENT, 16'hffff);
        wr(`SRR_SEL_OP_LIVE, 16'hffff);
        rdChk(`SRR_SEL_QS_EVENT, 16'h8000, "qsEvent");
        chkSb(8'h00);
        rdChk(`SRR_SEL_OP_LIVE, 16'h0000, "opLive");
        qsLive = '0;
        wrapUp();
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        badCount++;
        $display("ERROR watchdog expected end seen hang");
        wrapUp();
    end
endmodule // srr_status_tb
